// ===== fq_consts.svh
// constants of the flash query command handler
`ifndef FQ_CONSTS_SVH
`define FQ_CONSTS_SVH

// ----------------------------------------------------------------
// frame delimiters
// ----------------------------------------------------------------
`define FQ_SOH 8'h01
`define FQ_STX 8'h02
`define FQ_ETX 8'h03

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define FQ_ST_PRM 8'h05
`define FQ_ST_ACK 8'h06
`define FQ_ST_SUM 8'h07
`define FQ_ST_NACK 8'h15
`define FQ_ST_MRG 8'h1B
`define FQ_ST_RD 8'h20

// ----------------------------------------------------------------
// command codes and their frame_length_field values
// ----------------------------------------------------------------
`define FQ_CMD_STATUS 8'h70
`define FQ_CMD_BLANK 8'h32
`define FQ_CMD_SIG 8'hC0
`define FQ_CMD_VER 8'hC5
`define FQ_LEN_BLANK 8'h07
`define FQ_LEN_SHORT 8'h01
`define FQ_LEN_MAX 8'h07

// ----------------------------------------------------------------
// address layout: 24-bit address, 1 KB blocks
// ----------------------------------------------------------------
`define FQ_ADDR_W 24
`define FQ_BLK_LSB 10
`define FQ_BLK_OFS_FIRST 10'h000
`define FQ_BLK_OFS_LAST 10'h3FF

`endif

// ===== fq_pkg.sv
// types shared by the flash query command handler
package fq_pkg;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    // ----------------------------------------------------------------
    // state machines
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {RX_HEAD, RX_LEN, RX_BODY, RX_SUM, RX_ETX} rx_state_t;
    typedef enum logic [1:0] {M_IDLE, M_BLANK, M_SIG} main_state_t;
    typedef enum logic [2:0] {T_IDLE, T_STX, T_LEN, T_BODY, T_SUM, T_ETX} tx_state_t;

endpackage : fq_pkg

// ===== flash_query_command_handler.sv
// flash query command handler with its transmit fifo
`timescale 1ns/1ps
`include "fq_consts.svh"

// ----------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------
module fq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } ptr_t;

    ptr_t q;
    ptr_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign empty = (q.wr == q.rd);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[q.rd[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid_i && !full) begin
            d.wr = q.wr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // storage carries no reset; only the pointers say what is valid
    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[q.wr[AW-1:0]] <= in_data_i;
        end
    end
endmodule : fq_fifo

// ----------------------------------------------------------------
// command handler
// ----------------------------------------------------------------
// Notes on behaviour
// - ack 06H only when command ran and every block in range is erased
// - start or end address off a 1 KB block boundary gives 05H
// - received frame checksum mismatch gives 07H
// - malformed frame, bad length or missing end byte, gives 15H
// - while busy any non-status command gets 15H unless an answer frame is still being built; programmer sends only status
// - any block found not erased gives margin check error 1BH
// - signature: command, wait, status poll; the data frame follows the 06H status frame unasked
// - failure reading stored security information gives 20H
// - version: command, wait, status poll; the data frame follows the 06H status frame unasked
module flash_query_command_handler #(
    parameter int SIG_BYTES = 8,
    parameter int VER_BYTES = 4,
    parameter int FIFO_DEPTH = 16,
    // arbitrary value
    parameter logic [VER_BYTES*8-1:0] VERSION = 32'h0403_0201
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial link, byte level
    input wire fq_pkg::byte_beat_t rx_i,
    output fq_pkg::byte_beat_t tx_o,
    input wire logic tx_ready_i,
    // flash blank query
    output logic blank_req_o,
    output logic [`FQ_ADDR_W-`FQ_BLK_LSB-1:0] blank_block_o,
    input wire logic blank_done_i,
    input wire logic blank_erased_i,
    // security information read
    output logic sig_req_o,
    output logic [7:0] sig_idx_o,
    input wire logic sig_valid_i,
    input wire logic [7:0] sig_data_i,
    input wire logic sig_err_i,
    // status
    output logic busy_o,
    output logic [7:0] status_o
);
    localparam int BW = `FQ_ADDR_W - `FQ_BLK_LSB;
    localparam logic [VER_BYTES-1:0][7:0] VER_ARR = VERSION;

    typedef struct packed {
        fq_pkg::rx_state_t rx_st;
        logic [7:0] rx_cnt;
        logic [7:0] rx_len;
        logic [7:0] rx_sum;
        logic [7:0] rx_com;
        logic [5:0][7:0] prm;
        fq_pkg::main_state_t m_st;
        logic busy;
        logic [7:0] status;
        logic [BW-1:0] cur_blk;
        logic [BW-1:0] end_blk;
        logic blank_req;
        logic sig_req;
        logic [7:0] sig_idx;
        logic [SIG_BYTES-1:0][7:0] sig_buf;
        logic data_pend;
        logic data_ver;
        fq_pkg::tx_state_t tx_st;
        logic [7:0] tx_cnt;
        logic [7:0] tx_sum;
        logic [7:0] tx_code;
        logic tx_is_data;
        logic tx_chain;
        logic [7:0] chk_sum;
        fq_pkg::byte_beat_t out;
    } state_t;

    state_t q;
    state_t d;
    logic fr_done;
    logic frame_bad;
    logic push;
    logic [7:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_out_ready;
    logic [`FQ_ADDR_W-1:0] sa;
    logic [`FQ_ADDR_W-1:0] ea;
    logic [7:0] tx_len;
    logic [7:0] body_byte;

    assign sa = {q.prm[0], q.prm[1], q.prm[2]};
    assign ea = {q.prm[3], q.prm[4], q.prm[5]};
    assign tx_len = !q.tx_is_data ? `FQ_LEN_SHORT : (q.data_ver ? 8'(VER_BYTES) : 8'(SIG_BYTES));
    assign body_byte = !q.tx_is_data ? q.tx_code : (q.data_ver ? VER_ARR[q.tx_cnt] : q.sig_buf[q.tx_cnt]);
    assign fifo_out_ready = !q.out.valid || tx_ready_i;

    always_comb begin
        d = q;
        fr_done = 1'b0;
        frame_bad = 1'b0;
        push = 1'b0;
        fifo_in_data = 8'h00;
        // ----------------------------------------------------------------
        // command frame receive
        // ----------------------------------------------------------------
        if (rx_i.valid) begin
            case (q.rx_st)
                fq_pkg::RX_HEAD: begin
                    if (rx_i.data == `FQ_SOH) begin
                        d.rx_st = fq_pkg::RX_LEN;
                    end
                end
                fq_pkg::RX_LEN: begin
                    d.rx_len = rx_i.data;
                    d.rx_sum = rx_i.data;
                    d.rx_cnt = 8'h00;
                    d.rx_st = fq_pkg::RX_BODY;
                    if (rx_i.data == 8'h00 || rx_i.data > `FQ_LEN_MAX) begin
                        fr_done = 1'b1;
                        frame_bad = 1'b1;
                        d.rx_st = fq_pkg::RX_HEAD;
                    end
                end
                fq_pkg::RX_BODY: begin
                    if (q.rx_cnt == 8'h00) begin
                        d.rx_com = rx_i.data;
                    end else begin
                        d.prm[3'(q.rx_cnt - 8'h01)] = rx_i.data;
                    end
                    d.rx_sum = q.rx_sum + rx_i.data;
                    d.rx_cnt = q.rx_cnt + 8'h01;
                    if (q.rx_cnt + 8'h01 == q.rx_len) begin
                        d.rx_st = fq_pkg::RX_SUM;
                    end
                end
                fq_pkg::RX_SUM: begin
                    d.rx_sum = q.rx_sum + rx_i.data;
                    d.rx_st = fq_pkg::RX_ETX;
                end
                fq_pkg::RX_ETX: begin
                    fr_done = 1'b1;
                    frame_bad = (rx_i.data != `FQ_ETX);
                    d.rx_st = fq_pkg::RX_HEAD;
                end
                default: d.rx_st = fq_pkg::RX_HEAD;
            endcase
        end
        // ----------------------------------------------------------------
        // command decode
        // ----------------------------------------------------------------
        if (fr_done) begin
            if (q.busy) begin
                // a busy device answers straight away if no answer frame is being built, else drops it; it has no room to queue
                if ((frame_bad || q.rx_com != `FQ_CMD_STATUS) && q.tx_st == fq_pkg::T_IDLE) begin
                    d.tx_st = fq_pkg::T_STX;
                    d.tx_is_data = 1'b0;
                    d.tx_code = `FQ_ST_NACK;
                    d.tx_chain = 1'b0;
                end
            end else if (frame_bad) begin
                d.status = `FQ_ST_NACK;
            end else if (q.rx_sum != 8'h00) begin
                d.status = `FQ_ST_SUM;
            end else begin
                case (q.rx_com)
                    `FQ_CMD_STATUS: begin
                        if (q.rx_len != `FQ_LEN_SHORT) begin
                            d.status = `FQ_ST_NACK;
                        end else if (q.tx_st == fq_pkg::T_IDLE) begin
                            d.tx_st = fq_pkg::T_STX;
                            d.tx_is_data = 1'b0;
                            d.tx_code = q.status;
                            d.tx_chain = q.data_pend && q.status == `FQ_ST_ACK;
                            d.data_pend = 1'b0;
                        end
                    end
                    `FQ_CMD_BLANK: begin
                        d.data_pend = 1'b0;
                        if (q.rx_len != `FQ_LEN_BLANK) begin
                            d.status = `FQ_ST_NACK;
                        end else if (sa[`FQ_BLK_LSB-1:0] != `FQ_BLK_OFS_FIRST
                                     || ea[`FQ_BLK_LSB-1:0] != `FQ_BLK_OFS_LAST || ea < sa) begin
                            d.status = `FQ_ST_PRM;
                        end else begin
                            d.busy = 1'b1;
                            d.m_st = fq_pkg::M_BLANK;
                            d.blank_req = 1'b1;
                            d.cur_blk = sa[`FQ_ADDR_W-1:`FQ_BLK_LSB];
                            d.end_blk = ea[`FQ_ADDR_W-1:`FQ_BLK_LSB];
                        end
                    end
                    `FQ_CMD_SIG: begin
                        d.data_pend = 1'b0;
                        if (q.rx_len != `FQ_LEN_SHORT) begin
                            d.status = `FQ_ST_NACK;
                        end else begin
                            d.busy = 1'b1;
                            d.m_st = fq_pkg::M_SIG;
                            d.sig_req = 1'b1;
                            d.sig_idx = 8'h00;
                        end
                    end
                    `FQ_CMD_VER: begin
                        d.data_pend = (q.rx_len == `FQ_LEN_SHORT);
                        d.data_ver = 1'b1;
                        d.status = (q.rx_len == `FQ_LEN_SHORT) ? `FQ_ST_ACK : `FQ_ST_NACK;
                    end
                    default: begin
                        d.data_pend = 1'b0;
                        d.status = `FQ_ST_NACK;
                    end
                endcase
            end
        end
        // ----------------------------------------------------------------
        // command execution
        // ----------------------------------------------------------------
        case (q.m_st)
            fq_pkg::M_BLANK: begin
                if (blank_done_i) begin
                    if (!blank_erased_i || q.cur_blk == q.end_blk) begin
                        // first dirty block ends the scan early
                        d.status = blank_erased_i ? `FQ_ST_ACK : `FQ_ST_MRG;
                        d.busy = 1'b0;
                        d.blank_req = 1'b0;
                        d.m_st = fq_pkg::M_IDLE;
                    end else begin
                        d.cur_blk = q.cur_blk + 1'b1;
                    end
                end
            end
            fq_pkg::M_SIG: begin
                if (sig_err_i) begin
                    d.status = `FQ_ST_RD;
                    d.busy = 1'b0;
                    d.sig_req = 1'b0;
                    d.m_st = fq_pkg::M_IDLE;
                end else if (sig_valid_i) begin
                    d.sig_buf[q.sig_idx] = sig_data_i;
                    d.sig_idx = q.sig_idx + 8'h01;
                    if (q.sig_idx == 8'(SIG_BYTES - 1)) begin
                        d.status = `FQ_ST_ACK;
                        d.data_pend = 1'b1;
                        d.data_ver = 1'b0;
                        d.busy = 1'b0;
                        d.sig_req = 1'b0;
                        d.m_st = fq_pkg::M_IDLE;
                    end
                end
            end
            default: ;
        endcase
        // ----------------------------------------------------------------
        // answer frame build
        // ----------------------------------------------------------------
        case (q.tx_st)
            fq_pkg::T_STX: fifo_in_data = `FQ_STX;
            fq_pkg::T_LEN: fifo_in_data = tx_len;
            fq_pkg::T_BODY: fifo_in_data = body_byte;
            fq_pkg::T_SUM: fifo_in_data = 8'h00 - q.tx_sum;
            fq_pkg::T_ETX: fifo_in_data = `FQ_ETX;
            default: fifo_in_data = 8'h00;
        endcase
        push = (q.tx_st != fq_pkg::T_IDLE) && fifo_in_ready;
        if (push) begin
            case (q.tx_st)
                fq_pkg::T_STX: begin
                    d.tx_cnt = 8'h00;
                    d.tx_st = fq_pkg::T_LEN;
                end
                fq_pkg::T_LEN: begin
                    d.tx_sum = tx_len;
                    d.tx_st = fq_pkg::T_BODY;
                end
                fq_pkg::T_BODY: begin
                    d.tx_sum = q.tx_sum + body_byte;
                    d.tx_cnt = q.tx_cnt + 8'h01;
                    if (q.tx_cnt + 8'h01 == tx_len) begin
                        d.tx_st = fq_pkg::T_SUM;
                    end
                end
                fq_pkg::T_SUM: d.tx_st = fq_pkg::T_ETX;
                fq_pkg::T_ETX: begin
                    d.tx_is_data = q.tx_chain;
                    d.tx_chain = 1'b0;
                    d.tx_st = q.tx_chain ? fq_pkg::T_STX : fq_pkg::T_IDLE;
                end
                default: d.tx_st = fq_pkg::T_IDLE;
            endcase
        end
        // independent running sum of what really entered the fifo, for the frame check
        if (push && q.tx_st == fq_pkg::T_STX) begin
            d.chk_sum = 8'h00;
        end else if (push && q.tx_st != fq_pkg::T_ETX) begin
            d.chk_sum = q.chk_sum + fifo_in_data;
        end
        // registered output stage so tx_o comes from flops
        if (fifo_out_ready) begin
            d.out.valid = fifo_out_valid;
            d.out.data = fifo_out_valid ? fifo_out_data : q.out.data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    fq_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(q.tx_st != fq_pkg::T_IDLE),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign tx_o = q.out;
    assign blank_req_o = q.blank_req;
    assign blank_block_o = q.cur_blk;
    assign sig_req_o = q.sig_req;
    assign sig_idx_o = q.sig_idx;
    assign busy_o = q.busy;
    assign status_o = q.status;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_blank_ack;
        @(posedge clk_i) disable iff (rst_i)
        (q.m_st == fq_pkg::M_BLANK && blank_done_i && blank_erased_i && q.cur_blk == q.end_blk)
        |=> (status_o == `FQ_ST_ACK && !busy_o && !blank_req_o);
    endproperty
    a_blank_ack: assert property (p_blank_ack) else $error("blank check range clean but no ack");

    property p_prm_err;
        @(posedge clk_i) disable iff (rst_i)
        (fr_done && !q.busy && !frame_bad && q.rx_sum == 8'h00 && q.rx_com == `FQ_CMD_BLANK
         && q.rx_len == `FQ_LEN_BLANK && sa[`FQ_BLK_LSB-1:0] != `FQ_BLK_OFS_FIRST)
        |=> (status_o == `FQ_ST_PRM && !busy_o);
    endproperty
    a_prm_err: assert property (p_prm_err) else $error("unaligned start did not give parameter error");

    property p_sum_err;
        @(posedge clk_i) disable iff (rst_i)
        (fr_done && !q.busy && !frame_bad && q.rx_sum != 8'h00) |=> (status_o == `FQ_ST_SUM);
    endproperty
    a_sum_err: assert property (p_sum_err) else $error("bad frame checksum not reported");

    property p_frame_err;
        @(posedge clk_i) disable iff (rst_i)
        (fr_done && !q.busy && frame_bad) |=> (status_o == `FQ_ST_NACK);
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("malformed frame not refused");

    property p_busy_nack;
        @(posedge clk_i) disable iff (rst_i)
        (fr_done && q.busy && q.rx_com != `FQ_CMD_STATUS && q.tx_st == fq_pkg::T_IDLE)
        |=> (q.tx_st == fq_pkg::T_STX && q.tx_code == `FQ_ST_NACK && !q.tx_chain);
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("command during processing not refused");

    property p_margin;
        @(posedge clk_i) disable iff (rst_i)
        (q.m_st == fq_pkg::M_BLANK && blank_done_i && !blank_erased_i)
        |=> (status_o == `FQ_ST_MRG && !busy_o) ##1 (!blank_req_o);
    endproperty
    a_margin: assert property (p_margin) else $error("dirty block not reported as margin error");

    property p_read_err;
        @(posedge clk_i) disable iff (rst_i)
        (q.m_st == fq_pkg::M_SIG && sig_err_i) |=> (status_o == `FQ_ST_RD && !sig_req_o && !q.data_pend);
    endproperty
    a_read_err: assert property (p_read_err) else $error("signature read failure not reported");

    property p_tx_sum;
        @(posedge clk_i) disable iff (rst_i)
        (push && q.tx_st == fq_pkg::T_ETX) |-> (q.chk_sum == 8'h00);
    endproperty
    a_tx_sum: assert property (p_tx_sum) else $error("outgoing frame checksum wrong");
endmodule : flash_query_command_handler

// ===== fq_programmer_model.sv
// programmer side of the serial byte link
`timescale 1ns/1ps
module fq_programmer_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // byte link
    output fq_pkg::byte_beat_t rx_o,
    input wire fq_pkg::byte_beat_t tx_i,
    output logic tx_ready_o
);
    logic [7:0] fb [0:15];
    logic [127:0] frame_v;
    logic [7:0] acc;
    int n;
    event got;
    initial begin
        rx_o = '0;
        tx_ready_o = 1'b0;
        n = 0;
    end
    // ------------------------------------------------
    // command frames, optionally corrupted
    // ------------------------------------------------
    task automatic send(input logic [7:0] len, input logic [63:0] body, input logic bad_sum, input logic bad_etx);
        logic [7:0] b [0:11];
        logic [7:0] s;
        int k;
        b[0] = 8'h01;
        b[1] = len;
        s = len;
        for (k = 0; k < len; k++) begin
            b[k + 2] = body[8 * k +: 8];
            s += b[k + 2];
        end
        b[len + 2] = (8'h00 - s) ^ {7'h00, bad_sum};
        b[len + 3] = bad_etx ? 8'h04 : 8'h03;
        repeat (20) @(posedge clk_i); // command gap
        for (k = 0; k < len + 4; k++) begin
            @(posedge clk_i);
            rx_o <= '{1'b1, b[k]};
        end
        @(posedge clk_i);
        // idle data is not left at the last value
        rx_o <= '{1'b0, ~b[len + 3]};
    endtask : send
    // ------------------------------------------------
    // frame receiver with random stalls
    // ------------------------------------------------
    always @(posedge clk_i) begin
        tx_ready_o <= $urandom_range(3) != 0;
        if (rst_i) begin
            n = 0;
        end else if (tx_i.valid && tx_ready_o) begin
            fb[n[3:0]] = tx_i.data;
            n = n + 1;
            if (n > 1 && n == fb[1] + 4) begin // length taken from frame
                acc = 8'h00;
                frame_v = '0;
                for (int k = 0; k < n; k++) frame_v[8 * k +: 8] = fb[k];
                for (int k = 1; k < n - 1; k++) acc += fb[k]; // checksum
                n = 0;
                -> got;
            end
        end
    end
endmodule : fq_programmer_model

// ===== test_flash_query_command_handler.sv
// self-checking bench of the flash query command handler
`timescale 1ns/1ps
module test_flash_query_command_handler;
    logic clk_i, rst_i, tx_ready_i, blank_req_o, blank_done_i, blank_erased_i;
    logic sig_req_o, sig_valid_i, sig_err_i, busy_o, hold, sig_fail, bd, sd;
    logic [7:0] sig_idx_o, sig_data_i, status_o;
    logic [13:0] blank_block_o, dirty;
    logic [63:0] sig_pl;
    fq_pkg::byte_beat_t rx_i, tx_o;
    logic [127:0] exp_q[$];
    int n_mismatch, comparisons, cyc;
    flash_query_command_handler #(.VERSION(32'h0403_0201)) uut (.clk_i(clk_i), .rst_i(rst_i), .rx_i(rx_i),
        .tx_o(tx_o), .tx_ready_i(tx_ready_i), .blank_req_o(blank_req_o), .blank_block_o(blank_block_o),
        .blank_done_i(blank_done_i), .blank_erased_i(blank_erased_i), .sig_req_o(sig_req_o),
        .sig_idx_o(sig_idx_o), .sig_valid_i(sig_valid_i), .sig_data_i(sig_data_i), .sig_err_i(sig_err_i),
        .busy_o(busy_o), .status_o(status_o));
    fq_programmer_model prog (.clk_i(clk_i), .rst_i(rst_i), .rx_o(rx_i), .tx_i(tx_o), .tx_ready_o(tx_ready_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    function automatic logic [127:0] frm(input int len, input logic [63:0] pl);
        logic [127:0] v;
        logic [7:0] s;
        v = {112'h0, len[7:0], 8'h02};
        s = len[7:0];
        for (int k = 0; k < len; k++) begin
            v[8 * k + 16 +: 8] = pl[8 * k +: 8];
            s += pl[8 * k +: 8];
        end
        v[8 * len + 16 +: 8] = 8'h00 - s;
        v[8 * len + 24 +: 8] = 8'h03;
        return v;
    endfunction : frm
    function automatic logic [63:0] blk(input logic [23:0] s, input logic [23:0] e);
        return {8'h00, e[7:0], e[15:8], e[23:16], s[7:0], s[15:8], s[23:16], 8'h32};
    endfunction : blk
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // send a command, await its end, then poll status
    task automatic run(input logic [7:0] len, input logic [63:0] body, input logic bs, input logic be,
                       input logic [7:0] code, input int dat);
        int k;
        if (len != 8'h00) prog.send(len, body, bs, be);
        repeat (2) @(posedge clk_i);
        for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(posedge clk_i);
        #1;
        check(status_o, code);
        exp_q.push_back(frm(1, code));
        if (dat == 1) exp_q.push_back(frm(8, sig_pl));
        if (dat == 2) exp_q.push_back(frm(4, 64'h0403_0201));
        prog.send(8'h01, 64'h70, 1'b0, 1'b0);
    endtask : run
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------
    // flash side responder, stalls at random
    // ------------------------------------------------
    always @(posedge clk_i) begin
        bd = blank_req_o && !blank_done_i && !hold && $urandom_range(1) == 1;
        sd = sig_req_o && !sig_valid_i && !sig_err_i && $urandom_range(1) == 1;
        blank_done_i <= bd;
        blank_erased_i <= blank_block_o != dirty;
        sig_valid_i <= sd && !sig_fail;
        sig_err_i <= sd && sig_fail;
        sig_data_i <= sig_idx_o ^ 8'h5A;
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // result monitor
    initial forever begin
        @(prog.got);
        check({120'h0, prog.acc}, 128'h0);
        if (exp_q.size() == 0) check(prog.frame_v, 128'h0);
        else check(prog.frame_v, exp_q.pop_front());
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(32'hFFD4EB0D));
        {rst_i, hold, sig_fail, blank_done_i, blank_erased_i, sig_valid_i, sig_err_i} = 7'h40;
        sig_data_i = 8'h00;
        dirty = 14'h3FFF;
        for (int k = 0; k < 8; k++) sig_pl[8 * k +: 8] = k[7:0] ^ 8'h5A;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        run(8'h01, 64'hC5, 1'b0, 1'b0, 8'h06, 2);
        run(8'h01, 64'hC0, 1'b0, 1'b0, 8'h06, 1);
        sig_fail <= 1'b1;
        run(8'h01, 64'hC0, 1'b0, 1'b0, 8'h20, 0);
        sig_fail <= 1'b0;
        run(8'h07, blk(24'h000400, 24'h000FFF), 1'b0, 1'b0, 8'h06, 0);
        dirty <= 14'h0002;
        run(8'h07, blk(24'h000400, 24'h000FFF), 1'b0, 1'b0, 8'h1B, 0);
        run(8'h07, blk(24'h000401, 24'h000FFF), 1'b0, 1'b0, 8'h05, 0);
        run(8'h07, blk(24'h000400, 24'h000FFE), 1'b0, 1'b0, 8'h05, 0);
        run(8'h01, 64'hC5, 1'b1, 1'b0, 8'h07, 0);
        run(8'h01, 64'hC5, 1'b0, 1'b1, 8'h15, 0);
        run(8'h02, 64'h00C5, 1'b0, 1'b0, 8'h15, 0);
        dirty <= 14'h3FFF;
        hold <= 1'b1;
        prog.send(8'h07, blk(24'h000000, 24'h0013FF), 1'b0, 1'b0);
        exp_q.push_back(frm(1, 64'h15));
        prog.send(8'h01, 64'hC5, 1'b0, 1'b0);
        hold <= 1'b0;
        run(8'h00, 64'h0, 1'b0, 1'b0, 8'h06, 0);
        for (int k = 0; k < 5000 && exp_q.size() > 0; k++) @(posedge clk_i);
        check(exp_q.size(), 128'h0);
        tally_and_finish();
    end
endmodule : test_flash_query_command_handler
